// file: design/edge_sense.sv
/*
  Edge detector: one-cycle rise and fall pulses from a level.
  Assumes the level is already in the hclk domain.
*/
`timescale 1ns/1ps
module edge_sense (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic level,
  output port_irq_pkg::edge_pair_t edges
);

  logic level_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      level_r <= 1'b0;
    else
      level_r <= level;
  end

  // A level already high at reset release counts as a rise
  assign edges.rise = level & ~level_r;
  assign edges.fall = ~level & level_r;

endmodule : edge_sense

// file: design/port_irq_pkg.sv
/*
  Types for the digital port and interrupt group block.
  Assumes port_irq_regs.svh supplies the numeric constants.
*/
package port_irq_pkg;

  typedef struct packed {
    logic [11:0] rsvd;
    logic upper_out;
    logic lower_out;
    logic aux_out;
    logic aux_in;
    logic [7:0] port_upper_lane;
    logic [7:0] port_lower_lane;
  } digital_port_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic group2_pending_flag;
    logic [2:0] group2_condition_select;
    logic group1_pending_flag;
    logic [2:0] group1_condition_select;
    logic group0_pending_flag;
    logic [2:0] group0_condition_select;
  } interrupt_control_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
  } bus_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_pair_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_LOAD,
    BUS_READ_DONE
  } bus_state_t;

endpackage : port_irq_pkg

// file: design/port_irq_regs.svh
/*
  Register offsets, field positions, reset values and condition codes
  for the digital port and interrupt group block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PORT_IRQ_REGS_SVH
`define PORT_IRQ_REGS_SVH

////////////////////////////////////////////////////////////////////////////
// Offsets are held at the decoded width so the compare is width-exact
`define OFS_INTERRUPT_CONTROL 12'h004
`define OFS_DIGITAL_PORT 12'h024
`define ADDR_DECODE_MSB 11

`define RST_INTERRUPT_CONTROL 32'h0000_0008
`define RST_DIGITAL_PORT 32'h0000_0000

////////////////////////////////////////////////////////////////////////////
`define G0_FLAG_BIT 3
`define G1_FLAG_BIT 7
`define G2_FLAG_BIT 11

`define COND_IDLE 3'h0
`define G0_CALIB_DONE 3'h1
`define G0_AUX_RISE 3'h2
`define G0_AUX_FALL 3'h3
`define G1_IN_RISE 3'h1
`define G1_IN_FALL 3'h2
`define G2_OUT_RISE 3'h1
`define G2_OUT_FALL 3'h2
`define G2_BURST_END 3'h3

`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0

`endif

// file: design/port_irq_top.sv
/*
  Digital port with two direction-selectable lanes, auxiliary lines and a
  three-group interrupt controller, reached as an AHB-Lite slave.
  Assumes a single hclk domain; pins are synchronised here; buffer counts,
  thresholds and calibration status come from logic on hclk.
*/
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "port_irq_regs.svh"
module port_irq_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [15:0] port_in,
  output logic [15:0] port_out,
  output logic [15:0] port_oe,
  input wire logic aux_in,
  output logic aux_out,
  input wire logic calib_done,
  input wire logic [15:0] in_count,
  input wire logic [14:0] in_threshold,
  input wire logic [15:0] out_count,
  input wire logic [14:0] out_threshold,
  input wire logic out_word_done,
  input wire logic out_word_burst_end,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus front end

  port_irq_pkg::bus_state_t state_r;
  port_irq_pkg::bus_state_t state_nxt;
  port_irq_pkg::bus_req_t req_r;
  port_irq_pkg::bus_req_t req_nxt;
  logic accept;
  logic wr_en;
  logic rd_load;
  logic hit_ictl;
  logic hit_port;
  logic [31:0] rd_mux;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  assign accept = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;
  assign hit_ictl =
    req_r.addr[`ADDR_DECODE_MSB:0] == `OFS_INTERRUPT_CONTROL;
  assign hit_port =
    req_r.addr[`ADDR_DECODE_MSB:0] == `OFS_DIGITAL_PORT;
  assign wr_en = state_r == port_irq_pkg::BUS_WRITE;
  assign rd_load = state_r == port_irq_pkg::BUS_READ_LOAD;

  // Reads take one wait state so the data always leaves a flip-flop
  assign hreadyout = state_r != port_irq_pkg::BUS_READ_LOAD;
  assign hresp = `HRESP_OKAY;
  assign hrdata = hrdata_r;

  always_comb
  begin
    req_nxt = req_r;
    if (accept)
    begin
      req_nxt.addr = haddr;
      req_nxt.write = hwrite;
    end
  end

  always_comb
  begin
    state_nxt = port_irq_pkg::BUS_IDLE;
    case (state_r)
      port_irq_pkg::BUS_READ_LOAD:
        state_nxt = port_irq_pkg::BUS_READ_DONE;
      port_irq_pkg::BUS_IDLE,
      port_irq_pkg::BUS_WRITE,
      port_irq_pkg::BUS_READ_DONE:
      begin
        if (accept && hwrite)
          state_nxt = port_irq_pkg::BUS_WRITE;
        else if (accept)
          state_nxt = port_irq_pkg::BUS_READ_LOAD;
      end
      default:
        state_nxt = port_irq_pkg::BUS_IDLE;
    endcase
  end

  assign hrdata_nxt = rd_load ? rd_mux : hrdata_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= port_irq_pkg::BUS_IDLE;
      req_r <= '0;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [15:0] pin_meta_r;
  logic [15:0] pin_sync_r;
  logic aux_meta_r;
  logic aux_sync_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta_r <= 16'h0000;
      pin_sync_r <= 16'h0000;
      aux_meta_r <= 1'b0;
      aux_sync_r <= 1'b0;
    end
    else
    begin
      pin_meta_r <= port_in;
      pin_sync_r <= pin_meta_r;
      aux_meta_r <= aux_in;
      aux_sync_r <= aux_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Digital port register

  port_irq_pkg::digital_port_t port_r;
  port_irq_pkg::digital_port_t port_nxt;
  port_irq_pkg::digital_port_t port_view;
  logic wr_port;

  assign wr_port = wr_en & hit_port;

  always_comb
  begin
    port_nxt = port_r;
    if (wr_port)
    begin
      port_nxt = hwdata;
      // Read-only bits are never stored
      port_nxt.aux_in = 1'b0;
      port_nxt.rsvd = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      port_r <= `RST_DIGITAL_PORT;
    else
      port_r <= port_nxt;
  end

  // Lane enables follow the direction bits
  assign port_oe[7:0] = {8{port_r.lower_out}};
  assign port_oe[15:8] = {8{port_r.upper_out}};
  assign port_out = {port_r.port_upper_lane, port_r.port_lower_lane};
  assign aux_out = port_r.aux_out;

  always_comb
  begin
    port_view = port_r;
    port_view.aux_in = aux_sync_r;
    if (!port_r.lower_out)
      port_view.port_lower_lane = pin_sync_r[7:0];
    if (!port_r.upper_out)
      port_view.port_upper_lane = pin_sync_r[15:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition sources

  logic in_flag;
  logic out_flag;
  logic burst_end;
  logic [2:0] edge_src;
  port_irq_pkg::edge_pair_t edges [3];

  // Counts are compared as 16 bits so a full count above 7FFFh still counts
  assign in_flag = in_count > {1'b0, in_threshold};
  assign out_flag = out_count > {1'b0, out_threshold};
  assign burst_end = out_word_done & out_word_burst_end;
  assign edge_src = {out_flag, in_flag, aux_sync_r};

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_edge
      edge_sense u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .level(edge_src[i]),
        .edges(edges[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Interrupt groups

  port_irq_pkg::interrupt_control_t ictl_r;
  port_irq_pkg::interrupt_control_t ictl_nxt;
  logic wr_ictl;
  logic set0;
  logic set1;
  logic set2;
  logic clr0;
  logic clr1;
  logic clr2;

  assign wr_ictl = wr_en & hit_ictl;

  // Calibration done is a level: it keeps setting while it stays high
  assign set0 =
    (ictl_r.group0_condition_select == `G0_CALIB_DONE & calib_done) |
    (ictl_r.group0_condition_select == `G0_AUX_RISE & edges[0].rise) |
    (ictl_r.group0_condition_select == `G0_AUX_FALL & edges[0].fall);
  assign set1 =
    (ictl_r.group1_condition_select == `G1_IN_RISE & edges[1].rise) |
    (ictl_r.group1_condition_select == `G1_IN_FALL & edges[1].fall);
  assign set2 =
    (ictl_r.group2_condition_select == `G2_OUT_RISE & edges[2].rise) |
    (ictl_r.group2_condition_select == `G2_OUT_FALL & edges[2].fall) |
    (ictl_r.group2_condition_select == `G2_BURST_END & burst_end);

  // Writing one leaves a flag alone; only a written zero clears it
  assign clr0 = wr_ictl & ~hwdata[`G0_FLAG_BIT];
  assign clr1 = wr_ictl & ~hwdata[`G1_FLAG_BIT];
  assign clr2 = wr_ictl & ~hwdata[`G2_FLAG_BIT];

  always_comb
  begin
    ictl_nxt = ictl_r;
    if (wr_ictl)
    begin
      ictl_nxt.group0_condition_select = hwdata[2:0];
      ictl_nxt.group1_condition_select = hwdata[6:4];
      ictl_nxt.group2_condition_select = hwdata[10:8];
    end
    // A set in the clearing cycle wins so no event is lost
    ictl_nxt.group0_pending_flag =
      set0 | (ictl_r.group0_pending_flag & ~clr0);
    ictl_nxt.group1_pending_flag =
      set1 | (ictl_r.group1_pending_flag & ~clr1);
    ictl_nxt.group2_pending_flag =
      set2 | (ictl_r.group2_pending_flag & ~clr2);
    ictl_nxt.rsvd = '0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ictl_r <= `RST_INTERRUPT_CONTROL;
    else
      ictl_r <= ictl_nxt;
  end

  assign irq = ictl_r.group0_pending_flag |
               ictl_r.group1_pending_flag |
               ictl_r.group2_pending_flag;

  ////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read zero

  assign rd_mux = hit_ictl ? 32'(ictl_r) :
                  hit_port ? 32'(port_view) :
                  32'h0000_0000;

endmodule : port_irq_top

// file: tb/digital_port_and_irq_groups_test.sv
/*
  Self-checking bench: AHB-Lite master tasks, port and irq scenarios.
  Assumes port_irq_top and pin_world; hready is tied to hreadyout.
*/
`timescale 1ns/1ps
module digital_port_and_irq_groups_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic aux_in, aux_out, calib_done, out_word_done, out_word_burst_end;
  logic [15:0] port_in, port_out, port_oe, ext_val, in_count, out_count;
  logic [14:0] in_threshold, out_threshold;
  int num_errors = 0;
  int checks = 0;
  logic [31:0] tw [16] = '{32'h2, 32'h3, 32'h1, 32'h4, 32'h5, 32'h6,
    32'h7, 32'h10, 32'h20, 32'h30, 32'h70, 32'h100, 32'h200, 32'h300,
    32'h400, 32'h0};
  int tk [16] = '{0, 1, 2, 0, 1, 0, 1, 3, 4, 3, 4, 5, 6, 7, 5, 6};
  logic [0:15] te = 16'hE19C;
  assign hready = hreadyout;
  port_irq_top u_port_irq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .aux_in(aux_in),
    .aux_out(aux_out), .calib_done(calib_done), .in_count(in_count),
    .in_threshold(in_threshold), .out_count(out_count),
    .out_threshold(out_threshold), .out_word_done(out_word_done),
    .out_word_burst_end(out_word_burst_end), .irq(irq));
  pin_world u_pin_world (.port_out(port_out), .port_oe(port_oe),
    .ext_val(ext_val), .port_in(port_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      num_errors++;
    end
  endtask : chk
  // Samples hreadyout just before the edge, so no race with the slave
  task automatic rdy(output logic [31:0] q);
    logic r;
    for (int n = 0; n < 20; n++)
    begin
      @(negedge hclk);
      r = hreadyout;
      q = hrdata;
      @(posedge hclk);
      if (r === 1'h1)
        return;
    end
    num_errors++;
    results();
  endtask : rdy
  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy(q);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy(q);
  endtask : bus
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    chk({15'h0, aux_out, port_oe}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    bus(1'h1, 32'h40, 32'hFFFFFFFF, q);
    bus(1'h0, 32'h4, 32'h0, q);
    chk(q, 32'h8);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_port();
    logic [31:0] q;
    logic [1:0] d;
    ext_val <= 16'hC35A;
    for (int i = 0; i < 4; i++)
    begin
      d = i[1:0];
      bus(1'h1, 32'h24, {12'h0, d, d[0], 1'h0, 16'h3CA5}, q);
      repeat (3) @(posedge hclk);
      chk({15'h0, aux_out, port_oe},
        {15'h0, d[0], {8{d[1]}}, {8{d[0]}}});
      bus(1'h0, 32'h24, 32'h0, q);
      chk(q, {12'h0, d, d[0], 1'h0, d[1] ? 8'h3C : 8'hC3,
        d[0] ? 8'hA5 : 8'h5A});
    end
    $display("t_port done");
  endtask : t_port
  // Thresholds are 8, so counts 9 and 8 sit either side of the compare
  task automatic stim(input int k);
    case (k)
      0: aux_in <= 1'h1;
      1: aux_in <= 1'h0;
      2: calib_done <= 1'h1;
      3: in_count <= 16'h0009;
      4: in_count <= 16'h0008;
      5: out_count <= 16'h0009;
      6: out_count <= 16'h0008;
      default: {out_word_done, out_word_burst_end} <= 2'h3;
    endcase
    @(posedge hclk);
    calib_done <= 1'h0;
    {out_word_done, out_word_burst_end} <= 2'h0;
  endtask : stim
  task automatic trig(input logic [31:0] w, input int k, input logic e);
    logic [31:0] q;
    int b;
    b = w[2:0] != 3'h0 ? 3 : w[6:4] != 3'h0 ? 7 : 11;
    bus(1'h1, 32'h4, w, q);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    stim(k);
    repeat (6) @(posedge hclk);
    chk({31'h0, irq}, {31'h0, e});
    bus(1'h0, 32'h4, 32'h0, q);
    chk(q, w | (32'(e) << b));
  endtask : trig
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {aux_in, calib_done, out_word_done, out_word_burst_end} = '0;
    {ext_val, in_count, out_count} = '0;
    in_threshold = 15'h0008;
    out_threshold = 15'h0008;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_reset();
    t_port();
    for (int i = 0; i < 16; i++)
      trig(tw[i], tk[i], te[i]);
    $display("t_irq done");
    results();
  end
endmodule : digital_port_and_irq_groups_test

// file: tb/pin_world.sv
/*
  Pin-side partner: resolves the port pins seen by the block.
  Assumes ext_val is what outside gear drives on undriven pins.
*/
`timescale 1ns/1ps
module pin_world (
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  input wire logic [15:0] ext_val,
  output logic [15:0] port_in
);
  // Block drive wins where its enable is high; no contention model
  assign port_in = (port_oe & port_out) | (~port_oe & ext_val);
endmodule : pin_world

// file: tb/port_irq_props.sv
/*
  Checker bound to port_irq_top; sees its ports only.
  Assumes single-wait reads and zero-wait writes.
*/
`timescale 1ns/1ps
module port_irq_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [15:0] port_out,
  input wire logic [15:0] port_oe,
  input wire logic aux_out,
  input wire logic calib_done,
  input wire logic out_word_done,
  input wire logic out_word_burst_end,
  input wire logic irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////
  wire take = hsel && htrans[1] && hready;
  logic wp_r, wic_r, rp_r, ric_r;
  logic [2:0] g0_r, g2_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {wp_r, wic_r, rp_r, ric_r, g0_r, g2_r} <= '0;
    end
    else
    begin
      wp_r <= take && hwrite && haddr[11:0] == 12'h024;
      wic_r <= take && hwrite && haddr[11:0] == 12'h004;
      rp_r <= take && !hwrite && haddr[11:0] == 12'h024;
      ric_r <= take && !hwrite && haddr[11:0] == 12'h004;
      // Shadow of the group 0 and group 2 condition fields, so checks track software's choice
      if (wic_r && hready)
      begin
        g0_r <= hwdata[2:0];
        g2_r <= hwdata[10:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_oe_lanes: assert property (port_oe[7:0] == {8{port_oe[0]}} &&
    port_oe[15:8] == {8{port_oe[8]}}) else $error("lane enable split");
  a_oe_follow: assert property (wp_r && hready |=> port_oe ==
    {{8{$past(hwdata[19])}}, {8{$past(hwdata[18])}}})
    else $error("lane enable not as written");
  a_out_follow: assert property (wp_r && hready |=> port_out ==
    $past(hwdata[15:0]) && aux_out == $past(hwdata[17]))
    else $error("port outputs not as written");
  a_ic_read: assert property (ric_r |-> !hreadyout ##1
    (hreadyout && hrdata[31:12] == 20'h0)) else $error("bad control read");
  a_port_read: assert property (rp_r |-> !hreadyout ##1
    (hreadyout && hrdata[31:20] == 12'h0)) else $error("bad port read");
  a_irq_clear: assert property ($fell(irq) |->
    $past(wic_r) || $past(wic_r, 2)) else $error("irq fell without write");
  a_calib_level: assert property (g0_r == 3'h1 && calib_done
    |-> ##[1:2] irq) else $error("calibration did not raise irq");
  a_burst_irq: assert property (g2_r == 3'h3 && out_word_done &&
    out_word_burst_end |-> ##[1:2] irq) else $error("burst end missed");
endmodule : port_irq_props

bind port_irq_top port_irq_props u_props (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .port_out(port_out), .port_oe(port_oe), .aux_out(aux_out),
  .calib_done(calib_done), .out_word_done(out_word_done),
  .out_word_burst_end(out_word_burst_end), .irq(irq));
